// File: verilog/ccs_pkg.sv
package ccs_pkg;
  // register widths and reset values
  localparam int REG_W = 8;
  localparam logic [7:0] CLOCK_OP_MODE_RST = 8'h00;
  localparam logic [7:0] MAIN_OSC_CONTROL_RST = 8'h80;
  localparam logic [7:0] MAIN_CLOCK_MODE_RST = 8'h00;
  localparam logic [7:0] PROC_CLOCK_CONTROL_RST = 8'h00;
  localparam logic [7:0] INT_OSC_CONTROL_RST = 8'h00;
  // writable bits of each register
  localparam logic [7:0] CLOCK_OP_MODE_MASK = 8'hF1;
  localparam logic [7:0] MAIN_OSC_CONTROL_MASK = 8'h80;
  localparam logic [7:0] MAIN_CLOCK_MODE_MASK = 8'h05;
  localparam logic [7:0] PROC_CLOCK_CONTROL_MASK = 8'h50;
  localparam logic [7:0] INT_OSC_CONTROL_MASK = 8'h01;
  // field positions
  localparam int MAIN_EXT_INPUT_SEL_BIT = 7;
  localparam int MAIN_PIN_OSC_SEL_BIT = 6;
  localparam int SUB_EXT_INPUT_SEL_BIT = 5;
  localparam int SUB_PIN_OSC_SEL_BIT = 4;
  localparam int MAIN_OSC_GAIN_SEL_BIT = 0;
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int HIGH_SPEED_SOURCE_LOCK_BIT = 2;
  localparam int MAIN_CLOCK_SOURCE_SEL_BIT = 0;
  localparam int SUB_OSC_DIRECT_START_BIT = 6;
  localparam int SUBSYSTEM_CPU_SEL_BIT = 4;
  localparam int INTERNAL_OSC_STOP_BIT = 0;
  // timing
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int GAIN_HOLD_MIN_NS = 4060;
  localparam int GAIN_HOLD_MAX_NS = 16120;
  localparam int GAIN_HOLD_CYCLES = (GAIN_HOLD_MIN_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int GAIN_HOLD_EXT_EDGES = 160;
  localparam int SETTLE_CYCLES = 2048;
  localparam int HOLD_CNT_W = 8;
  // cpu clock source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_HIGH_SPEED = 2'h1;
  localparam logic [1:0] SRC_SUBSYSTEM = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN_INT = 3'h0,
    ST_RUN_HS = 3'h1,
    ST_RUN_SUB = 3'h2,
    ST_HALT_INT = 3'h3,
    ST_HALT_HS = 3'h4,
    ST_HALT_SUB = 3'h5,
    ST_STOP_INT = 3'h6,
    ST_STOP_HS = 3'h7
  } ccs_state_type;
endpackage

// File: verilog/ccs_cpu_clock_switcher.sv
`timescale 1ns/1ps
// Notes on behaviour
// - gain and source lock accept one write
// - halt enters halt state of current source
// - stop allowed from internal or high-speed source
// - gain rise with crystal holds cpu clock
// - gain rise with external clock holds 160 edges
// - internal oscillator stoppable once cpu left it
// - main stop halts crystal or blocks input unless cpu runs on high-speed source
// - internal oscillator stoppable while on subsystem
// - op mode bits seven, six, five, four, zero mapped
// - main stop bit seven, lock two, select zero
// - subsystem select sits at bit four
module ccs_cpu_clock_switcher #(
  parameter int SETTLE_CYCLES = ccs_pkg::SETTLE_CYCLES,
  parameter int SETTLE_W = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // register writes
  input wire logic clockOpModeWr,
  input wire logic mainOscControlWr,
  input wire logic mainClockModeWr,
  input wire logic procClockControlWr,
  input wire logic intOscControlWr,
  input wire logic [7:0] wrData,
  // cpu events and external clock pin level
  input wire logic haltExec,
  input wire logic stopExec,
  input wire logic wakeEvent,
  input wire logic mainExtClockIn,
  // register read-back
  output logic [7:0] clockOpModeReg,
  output logic [7:0] mainOscControlReg,
  output logic [7:0] mainClockModeReg,
  output logic [7:0] procClockControlReg,
  output logic [7:0] intOscControlReg,
  // status and oscillator controls
  output logic oscSettleCounterStatus,
  output logic cpuClockRun,
  output logic [1:0] cpuSource,
  output logic [2:0] powerState,
  output logic mainOscEnable,
  output logic mainExtInputEnable,
  output logic subOscEnable,
  output logic intOscEnable
);
  localparam int HOLD_CYCLES = ccs_pkg::GAIN_HOLD_CYCLES;
  localparam int HOLD_EDGES = ccs_pkg::GAIN_HOLD_EXT_EDGES;
  localparam logic [7:0] HOLD_CYC_INIT = HOLD_CYCLES[7:0];
  localparam logic [7:0] HOLD_EDGE_INIT = HOLD_EDGES[7:0];
  localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_CYCLES[SETTLE_W-1:0];

  function automatic logic [7:0] mergeBits(input logic [7:0] oldV, input logic [7:0] newV,
                                           input logic [7:0] mask);
    mergeBits = (oldV & ~mask) | (newV & mask);
  endfunction

  logic [7:0] opMode_reg, opMode_next;
  logic [7:0] mainOscCtl_reg, mainOscCtl_next;
  logic [7:0] mainClkMode_reg, mainClkMode_next;
  logic [7:0] procClk_reg, procClk_next;
  logic [7:0] intOscCtl_reg, intOscCtl_next;
  logic gainWritten_reg, lockWritten_reg;
  logic [ccs_pkg::HOLD_CNT_W-1:0] holdCnt_reg, holdCnt_next;
  logic holdExt_reg, holdExt_next;
  logic extPrev_reg;
  logic [SETTLE_W-1:0] settleCnt_reg, settleCnt_next;
  ccs_pkg::ccs_state_type state_reg, state_next;
  logic settle_reg, run_reg, mainEn_reg, extEn_reg, subEn_reg, intEn_reg;
  logic [1:0] source_reg;

  // write-once masks
  wire logic [7:0] opMask = ccs_pkg::CLOCK_OP_MODE_MASK &
    ~({7'h00, gainWritten_reg} << ccs_pkg::MAIN_OSC_GAIN_SEL_BIT);
  wire logic [7:0] clkModeMask = ccs_pkg::MAIN_CLOCK_MODE_MASK &
    ~({7'h00, lockWritten_reg} << ccs_pkg::HIGH_SPEED_SOURCE_LOCK_BIT);

  assign opMode_next = clockOpModeWr ? mergeBits(opMode_reg, wrData, opMask) : opMode_reg;
  assign mainOscCtl_next = mainOscControlWr ?
    mergeBits(mainOscCtl_reg, wrData, ccs_pkg::MAIN_OSC_CONTROL_MASK) : mainOscCtl_reg;
  assign mainClkMode_next = mainClockModeWr ?
    mergeBits(mainClkMode_reg, wrData, clkModeMask) : mainClkMode_reg;
  assign procClk_next = procClockControlWr ?
    mergeBits(procClk_reg, wrData, ccs_pkg::PROC_CLOCK_CONTROL_MASK) : procClk_reg;
  assign intOscCtl_next = intOscControlWr ?
    mergeBits(intOscCtl_reg, wrData, ccs_pkg::INT_OSC_CONTROL_MASK) : intOscCtl_reg;

  // decoded fields
  wire logic extSel = opMode_reg[ccs_pkg::MAIN_EXT_INPUT_SEL_BIT];
  wire logic pinSel = opMode_reg[ccs_pkg::MAIN_PIN_OSC_SEL_BIT];
  wire logic subExtSel = opMode_reg[ccs_pkg::SUB_EXT_INPUT_SEL_BIT];
  wire logic subPinSel = opMode_reg[ccs_pkg::SUB_PIN_OSC_SEL_BIT];
  wire logic mainStop = mainOscCtl_reg[ccs_pkg::MAIN_OSC_STOP_BIT];
  wire logic srcSel = mainClkMode_reg[ccs_pkg::MAIN_CLOCK_SOURCE_SEL_BIT];
  wire logic subStart = procClk_reg[ccs_pkg::SUB_OSC_DIRECT_START_BIT];
  wire logic subCpuSel = procClk_reg[ccs_pkg::SUBSYSTEM_CPU_SEL_BIT];
  wire logic intStop = intOscCtl_reg[ccs_pkg::INTERNAL_OSC_STOP_BIT];

  // current cpu clock source
  wire logic [1:0] sourceNow = subCpuSel ? ccs_pkg::SRC_SUBSYSTEM :
    (srcSel ? ccs_pkg::SRC_HIGH_SPEED : ccs_pkg::SRC_INTERNAL);
  wire logic inStop = (state_reg == ccs_pkg::ST_STOP_INT) || (state_reg == ccs_pkg::ST_STOP_HS);
  wire logic inRun = (state_reg == ccs_pkg::ST_RUN_INT) || (state_reg == ccs_pkg::ST_RUN_HS) ||
    (state_reg == ccs_pkg::ST_RUN_SUB);
  wire logic mainInUse = (sourceNow == ccs_pkg::SRC_HIGH_SPEED);
  wire logic intInUse = (sourceNow == ccs_pkg::SRC_INTERNAL);

  // oscillator enables
  wire logic mainStopOk = mainStop && !mainInUse;
  wire logic intStopOk = intStop && !intInUse;
  wire logic mainEnNext = pinSel && !extSel && !mainStopOk && !inStop;
  wire logic extEnNext = pinSel && extSel && !mainStopOk && !inStop;
  wire logic subEnNext = subStart || (subPinSel && !subExtSel);
  wire logic intEnNext = !intStopOk && !inStop;

  // gain rise and cpu clock hold-off
  wire logic gainRise = clockOpModeWr && !gainWritten_reg &&
    wrData[ccs_pkg::MAIN_OSC_GAIN_SEL_BIT] && !opMode_reg[ccs_pkg::MAIN_OSC_GAIN_SEL_BIT];
  wire logic newExtSel = opMode_next[ccs_pkg::MAIN_EXT_INPUT_SEL_BIT];
  wire logic extEdge = mainExtClockIn && !extPrev_reg;
  wire logic holdStep = (holdCnt_reg != 8'h00) && (!holdExt_reg || extEdge);
  assign holdCnt_next = gainRise ? (newExtSel ? HOLD_EDGE_INIT : HOLD_CYC_INIT) :
    (holdStep ? holdCnt_reg - 8'h01 : holdCnt_reg);
  assign holdExt_next = gainRise ? newExtSel : holdExt_reg;

  // stabilization counter for the main crystal
  wire logic settleDone = (settleCnt_reg == SETTLE_END);
  assign settleCnt_next = !mainEn_reg ? '0 :
    (settleDone ? settleCnt_reg : settleCnt_reg + 1'b1);

  // power state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ccs_pkg::ST_RUN_INT, ccs_pkg::ST_RUN_HS, ccs_pkg::ST_RUN_SUB: begin
        if (haltExec) begin
          case (sourceNow)
            ccs_pkg::SRC_HIGH_SPEED: state_next = ccs_pkg::ST_HALT_HS;
            ccs_pkg::SRC_SUBSYSTEM: state_next = ccs_pkg::ST_HALT_SUB;
            default: state_next = ccs_pkg::ST_HALT_INT;
          endcase
        end else if (stopExec && sourceNow != ccs_pkg::SRC_SUBSYSTEM) begin
          state_next = mainInUse ? ccs_pkg::ST_STOP_HS : ccs_pkg::ST_STOP_INT;
        end else begin
          case (sourceNow)
            ccs_pkg::SRC_HIGH_SPEED: state_next = ccs_pkg::ST_RUN_HS;
            ccs_pkg::SRC_SUBSYSTEM: state_next = ccs_pkg::ST_RUN_SUB;
            default: state_next = ccs_pkg::ST_RUN_INT;
          endcase
        end
      end
      ccs_pkg::ST_HALT_INT, ccs_pkg::ST_STOP_INT: begin
        if (wakeEvent) state_next = ccs_pkg::ST_RUN_INT;
      end
      ccs_pkg::ST_HALT_HS, ccs_pkg::ST_STOP_HS: begin
        if (wakeEvent) state_next = ccs_pkg::ST_RUN_HS;
      end
      ccs_pkg::ST_HALT_SUB: begin
        if (wakeEvent) state_next = ccs_pkg::ST_RUN_SUB;
      end
      default: state_next = ccs_pkg::ST_RUN_INT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opMode_reg <= ccs_pkg::CLOCK_OP_MODE_RST;
      mainOscCtl_reg <= ccs_pkg::MAIN_OSC_CONTROL_RST;
      mainClkMode_reg <= ccs_pkg::MAIN_CLOCK_MODE_RST;
      procClk_reg <= ccs_pkg::PROC_CLOCK_CONTROL_RST;
      intOscCtl_reg <= ccs_pkg::INT_OSC_CONTROL_RST;
      gainWritten_reg <= 1'b0;
      lockWritten_reg <= 1'b0;
      holdCnt_reg <= '0;
      holdExt_reg <= 1'b0;
      extPrev_reg <= 1'b0;
      settleCnt_reg <= '0;
      state_reg <= ccs_pkg::ST_RUN_INT;
    end else if (clkEn) begin
      opMode_reg <= opMode_next;
      mainOscCtl_reg <= mainOscCtl_next;
      mainClkMode_reg <= mainClkMode_next;
      procClk_reg <= procClk_next;
      intOscCtl_reg <= intOscCtl_next;
      gainWritten_reg <= gainWritten_reg | clockOpModeWr;
      lockWritten_reg <= lockWritten_reg | mainClockModeWr;
      holdCnt_reg <= holdCnt_next;
      holdExt_reg <= holdExt_next;
      extPrev_reg <= mainExtClockIn;
      settleCnt_reg <= settleCnt_next;
      state_reg <= state_next;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= 1'b0;
      run_reg <= 1'b0;
      source_reg <= ccs_pkg::SRC_INTERNAL;
      mainEn_reg <= 1'b0;
      extEn_reg <= 1'b0;
      subEn_reg <= 1'b0;
      intEn_reg <= 1'b1;
    end else if (clkEn) begin
      settle_reg <= settleDone && mainEn_reg;
      run_reg <= inRun && (holdCnt_next == 8'h00);
      source_reg <= sourceNow;
      mainEn_reg <= mainEnNext;
      extEn_reg <= extEnNext;
      subEn_reg <= subEnNext;
      intEn_reg <= intEnNext;
    end
  end

  assign clockOpModeReg = opMode_reg;
  assign mainOscControlReg = mainOscCtl_reg;
  assign mainClockModeReg = mainClkMode_reg;
  assign procClockControlReg = procClk_reg;
  assign intOscControlReg = intOscCtl_reg;
  assign oscSettleCounterStatus = settle_reg;
  assign cpuClockRun = run_reg;
  assign cpuSource = source_reg;
  assign powerState = state_reg;
  assign mainOscEnable = mainEn_reg;
  assign mainExtInputEnable = extEn_reg;
  assign subOscEnable = subEn_reg;
  assign intOscEnable = intEn_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  gain_write_once_a: assert property (clkEn && gainWritten_reg ##1 1'b1 |->
    $stable(opMode_reg[ccs_pkg::MAIN_OSC_GAIN_SEL_BIT]))
    else $error("gain bit changed after first write");
  lock_write_once_a: assert property (clkEn && lockWritten_reg |=>
    $stable(mainClkMode_reg[ccs_pkg::HIGH_SPEED_SOURCE_LOCK_BIT]))
    else $error("source lock changed after first write");
  crystal_hold_a: assert property (clkEn && gainRise && !newExtSel && inRun |=>
    !cpuClockRun && holdCnt_reg == HOLD_CYC_INIT)
    else $error("crystal gain hold-off not started");
  ext_hold_a: assert property (clkEn && gainRise && newExtSel |=>
    holdExt_reg && holdCnt_reg == HOLD_EDGE_INIT)
    else $error("external gain hold-off not started");
  hold_ends_a: assert property (clkEn && !holdExt_reg && holdCnt_reg == 8'h01 &&
    inRun && !gainRise |=> cpuClockRun)
    else $error("cpu clock not released after hold-off");
  halt_entry_a: assert property (clkEn && inRun && haltExec |=>
    (powerState == ccs_pkg::ST_HALT_INT && $past(sourceNow) == ccs_pkg::SRC_INTERNAL) ||
    (powerState == ccs_pkg::ST_HALT_HS && $past(sourceNow) == ccs_pkg::SRC_HIGH_SPEED) ||
    (powerState == ccs_pkg::ST_HALT_SUB && $past(sourceNow) == ccs_pkg::SRC_SUBSYSTEM))
    else $error("wrong halt state");
  stop_entry_a: assert property (clkEn && inRun && !haltExec && stopExec |=>
    ($past(sourceNow) == ccs_pkg::SRC_SUBSYSTEM) ? inRun :
    (powerState == ({1'b0, $past(mainInUse)} + 3'h6)))
    else $error("wrong stop state");
  int_stop_a: assert property (clkEn && intStop && !intInUse && !inStop |=> !intOscEnable)
    else $error("internal oscillator not stopped");
  main_stop_a: assert property (clkEn && mainStop && !mainInUse |=>
    !mainOscEnable && !mainExtInputEnable)
    else $error("main clock not stopped");

  halt_seen_c: cover property (inRun && haltExec ##1 !inRun);
  stop_seen_c: cover property (powerState == ccs_pkg::ST_STOP_HS);
  hold_seen_c: cover property (gainRise ##1 !cpuClockRun [*3]);
  sub_run_c: cover property (cpuSource == ccs_pkg::SRC_SUBSYSTEM && !intOscEnable);
endmodule

// File: test/ccs_ext_clock_model.sv
`timescale 1ns/1ps
// external main clock source on the oscillator pin; idles low while switched off
module ccs_ext_clock_model #(
  parameter int HALF_NS = 100
) (
  // source on/off
  input wire logic enable,
  // clock pin
  output logic clkOut
);
  initial begin
    clkOut = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      clkOut = enable ? ~clkOut : 1'b0;
    end
  end
endmodule

// File: test/tb_cpu_clock_source_switcher.sv
`timescale 1ns/1ps
module tb_cpu_clock_source_switcher;
  logic clk, resetn, clkEn, haltExec, stopExec, wakeEvent, extOn, mainExtClockIn;
  logic [4:0] wrSel;
  logic [7:0] wrData, clockOpModeReg, mainOscControlReg, mainClockModeReg;
  logic [7:0] procClockControlReg, intOscControlReg;
  logic oscSettleCounterStatus, cpuClockRun, mainOscEnable, mainExtInputEnable;
  logic subOscEnable, intOscEnable;
  logic [1:0] cpuSource;
  logic [2:0] powerState;
  int nMismatch = 0;
  int checksDone = 0;
  int n;

  ccs_ext_clock_model #(.HALF_NS(100)) extSrc (.enable(extOn), .clkOut(mainExtClockIn));

  ccs_cpu_clock_switcher #(.SETTLE_CYCLES(8)) dut (
    .clk(clk), .resetn(resetn), .clkEn(clkEn),
    .clockOpModeWr(wrSel[0]), .mainOscControlWr(wrSel[1]), .mainClockModeWr(wrSel[2]),
    .procClockControlWr(wrSel[3]), .intOscControlWr(wrSel[4]), .wrData(wrData),
    .haltExec(haltExec), .stopExec(stopExec), .wakeEvent(wakeEvent),
    .mainExtClockIn(mainExtClockIn),
    .clockOpModeReg(clockOpModeReg), .mainOscControlReg(mainOscControlReg),
    .mainClockModeReg(mainClockModeReg), .procClockControlReg(procClockControlReg),
    .intOscControlReg(intOscControlReg), .oscSettleCounterStatus(oscSettleCounterStatus),
    .cpuClockRun(cpuClockRun), .cpuSource(cpuSource), .powerState(powerState),
    .mainOscEnable(mainOscEnable), .mainExtInputEnable(mainExtInputEnable),
    .subOscEnable(subOscEnable), .intOscEnable(intOscEnable)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rng(input string name, input int v, input int lo, input int hi);
    checksDone++;
    if (v < lo || v > hi) begin
      nMismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, v);
    end
  endtask

  // register write: strobe index 0 op mode, 1 main osc, 2 clock mode, 3 proc, 4 internal
  task automatic wr(input int idx, input logic [7:0] d);
    @(negedge clk);
    wrSel = 5'h01 << idx;
    wrData = d;
    @(negedge clk);
    wrSel = 5'h00;
    repeat (2) @(negedge clk);
  endtask

  // cpu event: 0 halt, 1 stop, 2 wake
  task automatic ev(input int k);
    @(negedge clk);
    haltExec = (k == 0);
    stopExec = (k == 1);
    wakeEvent = (k == 2);
    @(negedge clk);
    {haltExec, stopExec, wakeEvent} = 3'h0;
    @(negedge clk);
  endtask

  task automatic holdCount(input int lim, output int cnt);
    int i;
    for (i = 0; i < lim && cpuClockRun !== 1'b1; i++) @(negedge clk);
    cnt = i + 3;
  endtask

  task automatic doReset;
    @(negedge clk);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    wrSel = 5'h00;
    wrData = 8'h00;
    {haltExec, stopExec, wakeEvent, extOn} = 4'h0;
    doReset;
    chk("reset regs", {clockOpModeReg, mainOscControlReg, mainClockModeReg,
        procClockControlReg, intOscControlReg}, 40'h0080000000);
    chk("reset outs", {intOscEnable, mainOscEnable, cpuClockRun, cpuSource, powerState},
        {3'h5, ccs_pkg::SRC_INTERNAL, ccs_pkg::ST_RUN_INT});
    $display("test reset done");
    wr(1, 8'h00);
    wr(0, 8'h41);
    holdCount(400, n);
    rng("crystal hold", n, 82, 322);
    chk("op mode", clockOpModeReg, 8'h41);
    chk("crystal on", {mainOscEnable, mainExtInputEnable}, 2'h2);
    chk("settle", oscSettleCounterStatus, 1'b1);
    wr(0, 8'h40);
    chk("gain once", {clockOpModeReg, cpuClockRun}, {8'h41, 1'b1});
    wr(2, 8'h05);
    chk("hs select", {mainClockModeReg, cpuSource}, {8'h05, ccs_pkg::SRC_HIGH_SPEED});
    wr(2, 8'h01);
    chk("lock once", mainClockModeReg, 8'h05);
    wr(4, 8'h01);
    chk("int stop", intOscEnable, 1'b0);
    ev(0);
    chk("halt hs", {powerState, cpuClockRun}, {ccs_pkg::ST_HALT_HS, 1'b0});
    ev(2);
    chk("wake hs", {powerState, cpuClockRun}, {ccs_pkg::ST_RUN_HS, 1'b1});
    ev(1);
    @(negedge clk);
    chk("stop hs", {powerState, mainOscEnable}, {ccs_pkg::ST_STOP_HS, 1'b0});
    ev(2);
    $display("test high-speed done");
    wr(4, 8'h00);
    wr(2, 8'h00);
    chk("back int", {mainClockModeReg, cpuSource, intOscEnable},
        {8'h04, ccs_pkg::SRC_INTERNAL, 1'b1});
    wr(1, 8'h80);
    chk("main stop", mainOscEnable, 1'b0);
    ev(0);
    chk("halt int", powerState, ccs_pkg::ST_HALT_INT);
    ev(2);
    ev(1);
    chk("stop int", powerState, ccs_pkg::ST_STOP_INT);
    ev(2);
    $display("test internal done");
    wr(3, 8'h40);
    chk("sub start", subOscEnable, 1'b1);
    wr(3, 8'h50);
    chk("sub select", {procClockControlReg, cpuSource}, {8'h50, ccs_pkg::SRC_SUBSYSTEM});
    wr(4, 8'h01);
    chk("int stop sub", intOscEnable, 1'b0);
    ev(1);
    chk("stop on sub", powerState, ccs_pkg::ST_RUN_SUB);
    ev(0);
    chk("halt sub", powerState, ccs_pkg::ST_HALT_SUB);
    ev(2);
    $display("test subsystem done");
    doReset;
    extOn = 1'b1;
    wr(1, 8'h00);
    wr(0, 8'hD1);
    holdCount(1000, n);
    rng("ext hold", n, 630, 650);
    chk("ext on", {mainExtInputEnable, mainOscEnable}, 2'h2);
    chk("sub pin", {subOscEnable, oscSettleCounterStatus}, 2'h2);
    wr(2, 8'h04);
    wr(1, 8'h80);
    chk("ext block", mainExtInputEnable, 1'b0);
    @(negedge clk);
    clkEn = 1'b0;
    ev(0);
    chk("freeze", powerState, ccs_pkg::ST_RUN_INT);
    clkEn = 1'b1;
    $display("test external done");
    conclude;
  end
endmodule
